// >>> design/eeu_edge_cap.sv
// Edge capture cell: catches short pulses asynchronously, reports synchronous pulses
`timescale 1ns/1ps
`default_nettype none
module eeu_edge_cap
   import eeu_pkg::*;
(
   // Clock and control
   input  wire logic clk_i,
   input  wire logic srst_i,
   input  wire logic ce_i,
   // Line input, possibly asynchronous
   input  wire logic line_i,
   // One-cycle pulses in the clock domain
   output logic      rise_o,
   output logic      fall_o
);
   logic rcap_ff;
   logic fcap_ff;
   logic rs1_ff, rs2_ff, rs3_ff, rclr_ff;
   logic fs1_ff, fs2_ff, fs3_ff, fclr_ff;
   logic nxt_rs1, nxt_rs2, nxt_rs3, nxt_rclr;
   logic nxt_fs1, nxt_fs2, nxt_fs3, nxt_fclr;

   // ------------------------------------------------------------
   // Asynchronous capture
   // ------------------------------------------------------------
   // Clocked by the line itself so pulses shorter than a clock period
   // still leave a mark; cleared by a registered, glitch-free strobe.
   always_ff @(posedge line_i or posedge rclr_ff) begin
      if (rclr_ff) begin
         rcap_ff <= EEU_RST_BIT;
      end else begin
         rcap_ff <= 1'h1;
      end
   end

   always_ff @(negedge line_i or posedge fclr_ff) begin
      if (fclr_ff) begin
         fcap_ff <= EEU_RST_BIT;
      end else begin
         fcap_ff <= 1'h1;
      end
   end

   // ------------------------------------------------------------
   // Synchronisers and clear handshake
   // ------------------------------------------------------------
   // Limitation: an edge arriving while its clear strobe is high is lost,
   // so two same-direction edges need a few clocks between them.
   always_comb begin
      nxt_rs1  = rcap_ff;
      nxt_rs2  = rs1_ff;
      nxt_rs3  = rs2_ff;
      nxt_rclr = rs2_ff;
      nxt_fs1  = fcap_ff;
      nxt_fs2  = fs1_ff;
      nxt_fs3  = fs2_ff;
      nxt_fclr = fs2_ff;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rs1_ff  <= EEU_RST_BIT;
         rs2_ff  <= EEU_RST_BIT;
         rs3_ff  <= EEU_RST_BIT;
         rclr_ff <= EEU_CLR_RST;
         fs1_ff  <= EEU_RST_BIT;
         fs2_ff  <= EEU_RST_BIT;
         fs3_ff  <= EEU_RST_BIT;
         fclr_ff <= EEU_CLR_RST;
      end else if (ce_i) begin
         rs1_ff  <= nxt_rs1;
         rs2_ff  <= nxt_rs2;
         rs3_ff  <= nxt_rs3;
         rclr_ff <= nxt_rclr;
         fs1_ff  <= nxt_fs1;
         fs2_ff  <= nxt_fs2;
         fs3_ff  <= nxt_fs3;
         fclr_ff <= nxt_fclr;
      end
   end

   assign rise_o = rs2_ff & ~rs3_ff;
   assign fall_o = fs2_ff & ~fs3_ff;
endmodule : eeu_edge_cap
`default_nettype wire

// >>> design/eeu_edge_event_unit.sv
// Edge event unit: per-line edge select, mask, pending status, interrupt and event requests
//
// Functional notes
// - Twenty-three independent edge lines, each raising interrupt or event requests.
// - Each line selects rising, falling, or both edges on its own.
// - Each line has its own mask; masking one leaves others untouched.
// - Per-line pending bit records a selected edge; software reads it.
// - Pulses shorter than one clock period are still caught.
// - Up to sixteen lines take a selectable GPIO pin; rest are internal.
// - Any line with its interrupt or event enable set drives WAKE_O, a register that only updates while MCLK_I runs.
`timescale 1ns/1ps
`default_nettype none
module eeu_edge_event_unit
   import eeu_pkg::*;
#(
   parameter int NUM_LINES     = EEU_NUM_LINES,
   parameter int NUM_PIN_LINES = EEU_NUM_PIN_LINES,
   parameter int NUM_PORTS     = EEU_NUM_PORTS,
   parameter int SEL_W         = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1
)
(
   // Clock, reset, enable
   input  wire logic                              MCLK_I,
   input  wire logic                              SYS_RST_I,
   input  wire logic                              CE_I,
   // Sources
   input  wire logic [NUM_PORTS*NUM_PIN_LINES-1:0] GPIO_I,
   input  wire logic [NUM_LINES-NUM_PIN_LINES-1:0] INT_SRC_I,
   // Configuration
   input  wire logic [NUM_PIN_LINES*SEL_W-1:0]    PORT_SEL_I,
   input  wire logic [NUM_LINES-1:0]              RISE_EN_I,
   input  wire logic [NUM_LINES-1:0]              FALL_EN_I,
   input  wire logic [NUM_LINES-1:0]              INT_ENA_I,
   input  wire logic [NUM_LINES-1:0]              EVT_ENA_I,
   // Pending clear
   input  wire logic [NUM_LINES-1:0]              PEND_CLR_I,
   input  wire logic                              PEND_CLR_WR_I,
   // Status and requests
   output logic      [NUM_LINES-1:0]              PEND_O,
   output logic      [NUM_LINES-1:0]              LINE_IRQ_O,
   output logic                                   IRQ_O,
   output logic      [NUM_LINES-1:0]              EVT_O,
   output logic                                   WAKE_O
);
   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (NUM_PIN_LINES > NUM_LINES || NUM_PIN_LINES < 1 || NUM_PORTS < 1)
      $error("eeu_edge_event_unit: unsupported line or port counts");
   if (NUM_LINES <= EEU_LINE_CMP_WAKE)
      $error("eeu_edge_event_unit: too few lines for the internal sources");

   logic [NUM_LINES-1:0] line_in;
   logic [NUM_LINES-1:0] rise_ev;
   logic [NUM_LINES-1:0] fall_ev;
   logic [NUM_LINES-1:0] edge_ev;
   logic [NUM_LINES-1:0] pend_ff,  nxt_pend;
   logic [NUM_LINES-1:0] lirq_ff,  nxt_lirq;
   logic [NUM_LINES-1:0] evt_ff,   nxt_evt;
   logic                 irq_ff,   nxt_irq;
   logic                 wake_ff,  nxt_wake;

   function automatic logic pick_pin(input logic [NUM_PORTS*NUM_PIN_LINES-1:0] pins,
                                     input int                                   idx,
                                     input logic [SEL_W-1:0]                     sel);
      logic r;
      r = 1'h0;
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (SEL_W'(p) == sel) begin
            r = pins[p*NUM_PIN_LINES+idx];
         end
      end
      return r;
   endfunction : pick_pin

   // ------------------------------------------------------------
   // Source routing and edge capture
   // ------------------------------------------------------------
   // Changing a port select can produce a false edge on that line;
   // software should reconfigure with the line's edges disabled.
   genvar g;
   for (g = 0; g < NUM_LINES; g++) begin : g_line
      if (g < NUM_PIN_LINES) begin : g_pin
         assign line_in[g] = pick_pin(GPIO_I, g, PORT_SEL_I[g*SEL_W +: SEL_W]);
      end else begin : g_int
         assign line_in[g] = INT_SRC_I[g-NUM_PIN_LINES];
      end

      eeu_edge_cap u_cap (
         .clk_i  (MCLK_I),
         .srst_i (SYS_RST_I),
         .ce_i   (CE_I),
         .line_i (line_in[g]),
         .rise_o (rise_ev[g]),
         .fall_o (fall_ev[g])
      );
   end

   assign edge_ev = (rise_ev & RISE_EN_I) | (fall_ev & FALL_EN_I);

   // ------------------------------------------------------------
   // Pending, requests, wake
   // ------------------------------------------------------------
   always_comb begin
      nxt_pend = pend_ff;
      if (PEND_CLR_WR_I) begin
         nxt_pend = nxt_pend & ~PEND_CLR_I;
      end
      nxt_pend = nxt_pend | edge_ev;
      nxt_lirq = nxt_pend & INT_ENA_I;
      nxt_irq  = |nxt_lirq;
      nxt_evt  = edge_ev & EVT_ENA_I;
      // Any unmasked edge wakes, whether routed as interrupt or event
      nxt_wake = |(edge_ev & (INT_ENA_I | EVT_ENA_I)) | nxt_irq;
   end

   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         pend_ff <= '0;
         lirq_ff <= '0;
         evt_ff  <= '0;
         irq_ff  <= EEU_RST_BIT;
         wake_ff <= EEU_RST_BIT;
      end else if (CE_I) begin
         pend_ff <= nxt_pend;
         lirq_ff <= nxt_lirq;
         evt_ff  <= nxt_evt;
         irq_ff  <= nxt_irq;
         wake_ff <= nxt_wake;
      end
   end

   assign PEND_O     = pend_ff;
   assign LINE_IRQ_O = lirq_ff;
   assign IRQ_O      = irq_ff;
   assign EVT_O      = evt_ff;
   assign WAKE_O     = wake_ff;
endmodule : eeu_edge_event_unit
`default_nettype wire

// >>> inc/eeu_pkg.sv
// Constants shared by the edge event unit and its capture cells
`default_nettype none
package eeu_pkg;
   // ------------------------------------------------------------
   // Line counts
   // ------------------------------------------------------------
   localparam int EEU_NUM_LINES     = 23;
   localparam int EEU_NUM_PIN_LINES = 16;
   localparam int EEU_NUM_PORTS     = 4;

   // ------------------------------------------------------------
   // Fixed internal source positions (after the pin lines)
   // ------------------------------------------------------------
   localparam int EEU_LINE_SUPPLY   = 16;
   localparam int EEU_LINE_CALENDAR = 17;
   localparam int EEU_LINE_USB_WAKE = 18;
   localparam int EEU_LINE_CMP_WAKE = 19;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic EEU_RST_BIT = 1'h0;
   localparam logic EEU_CLR_RST = 1'h1;
endpackage : eeu_pkg
`default_nettype wire

// >>> verification/eeu_monitor.sv
// Port checker for the edge event unit
`timescale 1ns/1ps
`default_nettype none
module eeu_monitor #(parameter int NUM_LINES = 23) (
   input wire logic                 MCLK_I,
   input wire logic                 SYS_RST_I,
   input wire logic                 CE_I,
   input wire logic [NUM_LINES-1:0] EVT_ENA_I,
   input wire logic [NUM_LINES-1:0] PEND_CLR_I,
   input wire logic                 PEND_CLR_WR_I,
   input wire logic [NUM_LINES-1:0] PEND_O,
   input wire logic [NUM_LINES-1:0] LINE_IRQ_O,
   input wire logic                 IRQ_O,
   input wire logic [NUM_LINES-1:0] EVT_O,
   input wire logic                 WAKE_O
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (SYS_RST_I);
   sequence s_clr;
      PEND_CLR_WR_I && CE_I;
   endsequence
   property p_irq; IRQ_O == (|LINE_IRQ_O); endproperty
   property p_lirq; (LINE_IRQ_O & ~PEND_O) == '0; endproperty
   property p_evt_pend; (EVT_O & ~PEND_O) == '0; endproperty
   property p_evt_ena; (EVT_O & ~EVT_ENA_I & ~$past(EVT_ENA_I)) == '0; endproperty
   property p_evt_pulse; |EVT_O |=> (EVT_O & $past(EVT_O)) == '0; endproperty
   property p_wake; |EVT_O |-> WAKE_O; endproperty
   // A reset edge one cycle back legally empties the pending bits
   property p_hold;
      !$past(SYS_RST_I) |-> (($past(PEND_O) & ~PEND_O) & ~($past(PEND_CLR_I)
         & {NUM_LINES{$past(PEND_CLR_WR_I) & $past(CE_I)}})) == '0;
   endproperty
   property p_freeze; !CE_I |=> $stable(PEND_O) && $stable(IRQ_O); endproperty
   property p_irq_drop; s_clr ##1 (PEND_O == '0) |-> !IRQ_O; endproperty
   property p_rst;
      disable iff (1'h0) SYS_RST_I |=> (PEND_O == '0 && LINE_IRQ_O == '0
         && EVT_O == '0 && !IRQ_O && !WAKE_O);
   endproperty
   a_irq: assert property (p_irq) else $error("irq not or of lines");
   a_lirq: assert property (p_lirq) else $error("line irq without pending");
   a_evt_pend: assert property (p_evt_pend) else $error("event without pending");
   a_evt_ena: assert property (p_evt_ena) else $error("event on masked line");
   a_evt_pulse: assert property (p_evt_pulse) else $error("event too long");
   a_wake: assert property (p_wake) else $error("event without wake");
   a_hold: assert property (p_hold) else $error("pending lost");
   a_irq_drop: assert property (p_irq_drop) else $error("irq after clear");
   a_rst: assert property (p_rst) else $error("outputs not idle in reset");
   a_freeze: assert property (p_freeze) else $error("state moved while disabled");
endmodule : eeu_monitor
bind eeu_edge_event_unit eeu_monitor #(.NUM_LINES(NUM_LINES)) i_eeu_monitor (
   .MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .CE_I(CE_I), .EVT_ENA_I(EVT_ENA_I),
   .PEND_CLR_I(PEND_CLR_I), .PEND_CLR_WR_I(PEND_CLR_WR_I), .PEND_O(PEND_O),
   .LINE_IRQ_O(LINE_IRQ_O), .IRQ_O(IRQ_O), .EVT_O(EVT_O), .WAKE_O(WAKE_O));
`default_nettype wire

// >>> verification/eeu_src_model.sv
// Model of the pins and internal sources
`timescale 1ns/1ps
`default_nettype none
module eeu_src_model (
   output logic [63:0] gpio_o,
   output logic [6:0]  src_o
);
   initial begin
      gpio_o = 64'h0;
      src_o  = 7'h0;
   end
   // Index 64 and up selects an internal source
   task automatic set(input int b, input logic v);
      if (b < 64) gpio_o[b] = v;
      else src_o[b-64] = v;
   endtask : set
   // Far narrower than a clock period, so only async capture sees it
   task automatic pulse(input int b);
      set(b, 1'h1);
      #10;
      set(b, 1'h0);
   endtask : pulse
endmodule : eeu_src_model
`default_nettype wire

// >>> verification/test_edge_event_interrupt_lines.sv
// Testbench for the edge event unit
`timescale 1ns/1ps
`default_nettype none
module test_edge_event_interrupt_lines;
   import eeu_pkg::*;
   logic clk = 1'h0, rst = 1'h1, ce = 1'h1, clr_wr = 1'h0, irq, wake;
   logic [63:0] gpio;
   logic [6:0]  src;
   logic [31:0] sel = 32'h0;
   logic [22:0] rise = 23'h0, fall = 23'h0, iena = 23'h0, eena = 23'h0, clr = 23'h0;
   logic [22:0] pend, lirq, evt;
   int errors = 0, comparisons = 0;
   initial forever #25 clk = ~clk;
   eeu_src_model i_eeu_src_model (.gpio_o(gpio), .src_o(src));
   eeu_edge_event_unit i_eeu_edge_event_unit (.MCLK_I(clk), .SYS_RST_I(rst), .CE_I(ce),
      .GPIO_I(gpio), .INT_SRC_I(src), .PORT_SEL_I(sel), .RISE_EN_I(rise), .FALL_EN_I(fall),
      .INT_ENA_I(iena), .EVT_ENA_I(eena), .PEND_CLR_I(clr), .PEND_CLR_WR_I(clr_wr),
      .PEND_O(pend), .LINE_IRQ_O(lirq), .IRQ_O(irq), .EVT_O(evt), .WAKE_O(wake));
   task automatic complete_run();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [22:0] exp, input logic [22:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : cyc
   // Bounded wait; answer arrives within three edges of the pin edge
   task automatic wait_pend(input int k);
      int n;
      n = 0;
      while (pend[k] !== 1'h1 && n < 6) begin
         cyc(1);
         n++;
      end
      chk("pend bit", 23'h1, {22'h0, pend[k]});
      if (n == 6) complete_run();
   endtask : wait_pend
   task automatic wr_clr(input logic [22:0] m);
      clr = m;
      clr_wr = 1'h1;
      cyc(1);
      clr_wr = 1'h0;
      chk("pend after clear", 23'h0, pend & m);
   endtask : wr_clr
   task automatic t_rise();
      rise[3] = 1'h1; iena[3] = 1'h1; eena[3] = 1'h1;
      cyc(2);
      i_eeu_src_model.pulse(3);
      wait_pend(3);
      chk("evt", 23'h8, evt);
      chk("wake", 23'h1, {22'h0, wake});
      chk("irq", 23'h1, {22'h0, irq});
      cyc(6);
      chk("pend held", 23'h8, pend);
      chk("evt ended", 23'h0, evt);
      wr_clr(23'h8);
      chk("irq cleared", 23'h0, {22'h0, irq});
   endtask : t_rise
   task automatic t_fall();
      sel[11:10] = 2'h2; fall[5] = 1'h1; iena[5] = 1'h1;
      cyc(2);
      i_eeu_src_model.set(37, 1'h1);
      i_eeu_src_model.pulse(5);
      cyc(6);
      chk("pend no fall", 23'h0, pend);
      i_eeu_src_model.set(37, 1'h0);
      wait_pend(5);
      chk("line irq", 23'h20, lirq);
      wr_clr(23'h20);
   endtask : t_fall
   task automatic t_mask();
      rise[16] = 1'h1;
      i_eeu_src_model.pulse(64);
      wait_pend(EEU_LINE_SUPPLY);
      chk("masked line irq", 23'h0, lirq | evt);
      chk("masked wake", 23'h0, {22'h0, wake});
      iena[16] = 1'h1;
      cyc(2);
      chk("unmasked line irq", 23'h10000, lirq);
      chk("unmasked wake", 23'h1, {22'h0, wake});
      wr_clr(23'h10000);
   endtask : t_mask
   task automatic t_both();
      rise[17] = 1'h1; fall[17] = 1'h1;
      i_eeu_src_model.set(65, 1'h1);
      wait_pend(EEU_LINE_CALENDAR);
      wr_clr(23'h20000);
      cyc(5);
      i_eeu_src_model.set(65, 1'h0);
      wait_pend(EEU_LINE_CALENDAR);
      wr_clr(23'h20000);
   endtask : t_both
   // Edge arrives while the clock enable is low: held by the capture flop
   task automatic t_freeze();
      ce = 1'h0;
      i_eeu_src_model.pulse(3);
      cyc(4);
      chk("pend frozen", 23'h0, pend);
      ce = 1'h1;
      wait_pend(3);
      chk("evt after freeze", 23'h8, evt);
      wr_clr(23'h8);
   endtask : t_freeze
   // Mid-run reset empties all requests; the line works again afterwards
   task automatic t_reset();
      cyc(5);
      i_eeu_src_model.pulse(3);
      wait_pend(3);
      rst = 1'h1;
      cyc(2);
      rst = 1'h0;
      chk("pend after reset", 23'h0, pend | lirq | evt);
      chk("irq after reset", 23'h0, {21'h0, irq, wake});
      cyc(4);
      i_eeu_src_model.pulse(3);
      wait_pend(3);
      chk("irq after restart", 23'h1, {22'h0, irq});
      wr_clr(23'h8);
   endtask : t_reset
   initial begin
      cyc(20);
      chk("pend in reset", 23'h0, pend);
      rst = 1'h0;
      cyc(5);
      t_rise();
      t_fall();
      t_mask();
      t_both();
      t_freeze();
      t_reset();
      complete_run();
   end
endmodule : test_edge_event_interrupt_lines
`default_nettype wire
